// *** logic/dtm_pkg.sv ***
package dtm_pkg;

  // instance decode: the upper address bits select one of two timers
  localparam logic [31:0] FIRST_INSTANCE_BASE = 32'h40d0_0000;
  localparam logic [31:0] SECOND_INSTANCE_BASE = 32'h40e0_0000;
  localparam logic [31:0] PAGE_MASK = 32'hffff_ff00;

  // register byte offsets inside one instance
  localparam logic [7:0] OFS_COUNTER_ONE = 8'h00;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_A = 8'h04;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_B = 8'h08;
  localparam logic [7:0] OFS_COUNTER_TWO = 8'h0c;
  localparam logic [7:0] OFS_PRESCALE_DIVIDER = 8'h10;
  localparam logic [7:0] OFS_CLOCK_UNIT_SETUP = 8'h14;
  localparam logic [7:0] OFS_MODE_SETUP = 8'h18;
  localparam logic [7:0] OFS_IRQ_SETUP = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;

  // field widths
  localparam int COUNT_W = 16;
  localparam int PRESCALE_W = 8;
  localparam int CLOCK_SETUP_W = 6;
  localparam int CSEL_W = 3;
  localparam int MODE_W = 9;
  localparam int IRQ_W = 4;

  // clock_unit_setup fields
  localparam int CSEL_ONE_LSB = 0;
  localparam int CSEL_TWO_LSB = 3;
  localparam logic [2:0] CSEL_STOPPED = 3'h0;
  localparam logic [2:0] CSEL_PRESCALED = 3'h1;
  localparam logic [2:0] CSEL_EVENT_B = 3'h2;

  // mode_setup fields
  localparam int MODE_SEL_LSB = 0;
  localparam logic [1:0] MODE_PWM = 2'h0;
  localparam logic [1:0] MODE_DUAL_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_DUAL_COUNTER = 2'h2;
  localparam logic [1:0] MODE_CAPTURE_TIMER = 2'h3;
  localparam int EDGE_B_BIT = 3;
  localparam int ENABLE_B_BIT = 5;
  localparam int GLOBAL_ENABLE_BIT = 6;
  localparam int PULSE_TRAIN_BIT = 7;
  localparam int EVENT_TRIGGER_BIT = 8;
  localparam int PULSE_START_BIT = 9;

  // irq_setup / irq_clear fields: flags a..d, enables in low nibble
  localparam int PEND_A = 0;
  localparam int PEND_B = 1;
  localparam int PEND_D = 3;
  localparam int PEND_LSB = 4;

  // reset values, and the preset loaded into a counter on capture
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [5:0] CLOCK_SETUP_RST = 6'h00;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [15:0] PRESET_VALUE = 16'hffff;

endpackage

// *** logic/dtm_prescaler.sv ***
`timescale 1ns/10ps
module dtm_prescaler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic pulse_mode_in,
  input wire logic load_now_in,
  input wire logic [7:0] divider_in,
  output logic tick_out
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] active_q;
  logic [7:0] active_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    count_d = count_q;
    active_d = active_q;
    tick_d = 1'b0;
    if (!run_in) begin
      // restart from a fresh divider so the first tick after enable is a full period
      count_d = divider_in;
      active_d = divider_in;
    end else if (pulse_mode_in && load_now_in) begin
      count_d = divider_in;
      active_d = divider_in;
    end else if (count_q == 8'h00) begin
      tick_d = 1'b1;
      if (pulse_mode_in) begin
        count_d = active_q;
      end else begin
        count_d = divider_in;
        active_d = divider_in;
      end
    end else begin
      count_d = count_q - 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= dtm_pkg::PRESCALE_RST;
      active_q <= dtm_pkg::PRESCALE_RST;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      active_q <= active_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

// *** logic/dtm_timer_regs.sv ***
// What this block does
// - two identical timers, decoded at two fixed base addresses
// - nine word registers per timer, offsets 0x00 through 0x20
// - counter one: 16-bit read/write, never reset, random at power-up
// - counter two: 16-bit read/write, never reset, random at power-up
// - reading a counter returns its live count
// - reload/capture a: 16 bits, no reset, always readable
// - writes to reload/capture a land only while global enable is 1
// - reload/capture b: 16 bits, no reset, readable, writable only when enabled
// - prescaler: 8-bit read/write, resets to zero, writable any time
// - outside pulse-train mode a new prescaler value loads at underflow
// - in pulse-train mode it loads on start or on triggered input b event
// - timer tick is system clock divided by prescaler plus one
// - clock select 000 stops a counter, 001 uses the prescaled tick
// - counter one reloads from reload/capture a on underflow
// - in capture-timer mode an input b edge copies counter two into reload/capture b, sets pending
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module dtm_timer_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [1:0] input_b_pin_in,
  output logic [31:0] rdata_out,
  output logic [1:0] timer_tick_out,
  output logic [1:0] timer_global_enable_out
);

  // {hit, instance}
  function automatic logic [1:0] decode_instance(input logic [31:0] addr);
    logic [1:0] res;
    res = 2'h0;
    if (addr[1:0] == 2'h0 && addr[7:0] <= dtm_pkg::OFS_IRQ_CLEAR) begin
      if ((addr & dtm_pkg::PAGE_MASK) == dtm_pkg::FIRST_INSTANCE_BASE) begin
        res = 2'h2;
      end else if ((addr & dtm_pkg::PAGE_MASK) == dtm_pkg::SECOND_INSTANCE_BASE) begin
        res = 2'h3;
      end
    end
    return res;
  endfunction

  function automatic logic [2:0] clock_select(input logic [5:0] setup, input logic second);
    logic [2:0] res;
    res = second ? setup[dtm_pkg::CSEL_TWO_LSB +: dtm_pkg::CSEL_W]
                 : setup[dtm_pkg::CSEL_ONE_LSB +: dtm_pkg::CSEL_W];
    return res;
  endfunction

  // configuration and status, reset group
  logic [7:0] prescale_q [2];
  logic [7:0] prescale_d [2];
  logic [5:0] clock_setup_q [2];
  logic [5:0] clock_setup_d [2];
  logic [8:0] mode_q [2];
  logic [8:0] mode_d [2];
  logic [3:0] irq_en_q [2];
  logic [3:0] irq_en_d [2];
  logic [3:0] pend_q [2];
  logic [3:0] pend_d [2];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_last_q;
  logic [1:0] enable_q;
  logic [1:0] enable_d;

  // data registers, deliberately outside reset
  logic [15:0] cnt1_q [2];
  logic [15:0] cnt1_d [2];
  logic [15:0] cnt2_q [2];
  logic [15:0] cnt2_d [2];
  logic [15:0] cra_q [2];
  logic [15:0] cra_d [2];
  logic [15:0] crb_q [2];
  logic [15:0] crb_d [2];

  // per-instance events
  logic [1:0] hit_sel;
  logic [1:0] wr_sel;
  logic [1:0] b_event;
  logic [1:0] pulse_mode;
  logic [1:0] pulse_load;
  logic [1:0] c1_step;
  logic [1:0] c1_uflow;
  logic [1:0] c2_step;
  logic [1:0] c2_uflow;
  logic [1:0] cap_two_b;
  logic [1:0] preset_two;
  logic [1:0] cap_one_a;
  logic [1:0] cap_one_b;
  logic [1:0] preset_one;
  logic [1:0] tick;
  logic [1:0] dec;

  assign dec = decode_instance(addr_in);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [2:0] cs1;
      logic [2:0] cs2;
      logic [1:0] mode;
      logic edge_seen;
      cs1 = clock_select(clock_setup_q[i], 1'b0);
      cs2 = clock_select(clock_setup_q[i], 1'b1);
      mode = mode_q[i][dtm_pkg::MODE_SEL_LSB +: 2];
      hit_sel[i] = dec[1] && (dec[0] == i[0]);
      wr_sel[i] = wr_in && hit_sel[i];
      // edge detect reads only the second synchroniser stage and its delayed copy
      edge_seen = mode_q[i][dtm_pkg::EDGE_B_BIT] ? (pin_sync_q[i] && !pin_last_q[i])
                                               : (!pin_sync_q[i] && pin_last_q[i]);
      b_event[i] = edge_seen && mode_q[i][dtm_pkg::GLOBAL_ENABLE_BIT];
      pulse_mode[i] = (mode == dtm_pkg::MODE_PWM) && mode_q[i][dtm_pkg::PULSE_TRAIN_BIT];
      pulse_load[i] = (wr_sel[i] && addr_in[7:0] == dtm_pkg::OFS_MODE_SETUP
                       && wdata_in[dtm_pkg::PULSE_START_BIT])
                      || (b_event[i] && mode_q[i][dtm_pkg::EVENT_TRIGGER_BIT]);
      // stopped selects and pulse-accumulate leave the counter frozen
      c1_step[i] = enable_q[i] && ((cs1 == dtm_pkg::CSEL_PRESCALED && tick[i])
                   || (cs1 == dtm_pkg::CSEL_EVENT_B && b_event[i]
                       && (mode == dtm_pkg::MODE_PWM || mode == dtm_pkg::MODE_DUAL_COUNTER)));
      c2_step[i] = enable_q[i] && cs2 == dtm_pkg::CSEL_PRESCALED && tick[i];
      c1_uflow[i] = c1_step[i] && cnt1_q[i] == 16'h0000;
      c2_uflow[i] = c2_step[i] && cnt2_q[i] == 16'h0000;
      cap_two_b[i] = b_event[i] && mode == dtm_pkg::MODE_CAPTURE_TIMER;
      preset_two[i] = cap_two_b[i] && mode_q[i][dtm_pkg::ENABLE_B_BIT];
      cap_one_a[i] = b_event[i] && mode == dtm_pkg::MODE_DUAL_CAPTURE
                     && mode_q[i][dtm_pkg::ENABLE_B_BIT];
      cap_one_b[i] = b_event[i] && mode == dtm_pkg::MODE_DUAL_CAPTURE
                     && !mode_q[i][dtm_pkg::ENABLE_B_BIT];
      preset_one[i] = cap_one_a[i];
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_prescale
      dtm_prescaler u_prescaler (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(enable_q[g]),
        .pulse_mode_in(pulse_mode[g]),
        .load_now_in(pulse_load[g]),
        .divider_in(prescale_q[g]),
        .tick_out(tick[g])
      );
    end
  endgenerate

  // counters and reload/capture values
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cnt1_d[i] = cnt1_q[i];
      cnt2_d[i] = cnt2_q[i];
      cra_d[i] = cra_q[i];
      crb_d[i] = crb_q[i];
      if (c1_uflow[i]) begin
        cnt1_d[i] = cra_q[i];
      end else if (c1_step[i]) begin
        cnt1_d[i] = cnt1_q[i] - 16'h0001;
      end
      if (c2_step[i]) begin
        cnt2_d[i] = cnt2_q[i] - 16'h0001;
      end
      // software writes: the low half only, upper bits have nowhere to go
      if (wr_sel[i] && addr_in[7:0] == dtm_pkg::OFS_COUNTER_ONE) begin
        cnt1_d[i] = wdata_in[15:0];
      end
      if (wr_sel[i] && addr_in[7:0] == dtm_pkg::OFS_COUNTER_TWO) begin
        cnt2_d[i] = wdata_in[15:0];
      end
      if (wr_sel[i] && enable_q[i] && addr_in[7:0] == dtm_pkg::OFS_RELOAD_CAPTURE_A) begin
        cra_d[i] = wdata_in[15:0];
      end
      if (wr_sel[i] && enable_q[i] && addr_in[7:0] == dtm_pkg::OFS_RELOAD_CAPTURE_B) begin
        crb_d[i] = wdata_in[15:0];
      end
      // hardware captures beat a same-cycle software write so no event is lost
      if (cap_one_a[i]) begin
        cra_d[i] = cnt1_q[i];
      end
      if (cap_one_b[i]) begin
        crb_d[i] = cnt1_q[i];
      end
      if (cap_two_b[i]) begin
        crb_d[i] = cnt2_q[i];
      end
      if (preset_one[i]) begin
        cnt1_d[i] = dtm_pkg::PRESET_VALUE;
      end
      if (preset_two[i]) begin
        cnt2_d[i] = dtm_pkg::PRESET_VALUE;
      end
    end
  end

  // no reset here: contents are undefined until software loads them
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      cnt1_q[i] <= cnt1_d[i];
      cnt2_q[i] <= cnt2_d[i];
      cra_q[i] <= cra_d[i];
      crb_q[i] <= crb_d[i];
    end
  end

  // configuration, flags and read data
  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < 2; i++) begin
      logic [3:0] clear;
      logic [3:0] set;
      prescale_d[i] = prescale_q[i];
      clock_setup_d[i] = clock_setup_q[i];
      mode_d[i] = mode_q[i];
      irq_en_d[i] = irq_en_q[i];
      clear = 4'h0;
      set = 4'h0;
      if (wr_sel[i]) begin
        unique case (addr_in[7:0])
          dtm_pkg::OFS_PRESCALE_DIVIDER: prescale_d[i] = wdata_in[7:0];
          dtm_pkg::OFS_CLOCK_UNIT_SETUP: clock_setup_d[i] = wdata_in[5:0];
          dtm_pkg::OFS_MODE_SETUP: mode_d[i] = wdata_in[8:0];
          dtm_pkg::OFS_IRQ_SETUP: irq_en_d[i] = wdata_in[3:0];
          dtm_pkg::OFS_IRQ_CLEAR: clear = wdata_in[3:0];
          default: clear = 4'h0;
        endcase
      end
      set[dtm_pkg::PEND_A] = c1_uflow[i];
      set[dtm_pkg::PEND_B] = cap_two_b[i] || cap_one_a[i] || cap_one_b[i];
      set[dtm_pkg::PEND_D] = c2_uflow[i];
      // set wins over a clear arriving in the same cycle
      pend_d[i] = (pend_q[i] & ~clear) | set;
      enable_d[i] = mode_d[i][dtm_pkg::GLOBAL_ENABLE_BIT];
      if (rd_in && hit_sel[i]) begin
        unique case (addr_in[7:0])
          dtm_pkg::OFS_COUNTER_ONE: rdata_d = {16'h0000, cnt1_q[i]};
          dtm_pkg::OFS_RELOAD_CAPTURE_A: rdata_d = {16'h0000, cra_q[i]};
          dtm_pkg::OFS_RELOAD_CAPTURE_B: rdata_d = {16'h0000, crb_q[i]};
          dtm_pkg::OFS_COUNTER_TWO: rdata_d = {16'h0000, cnt2_q[i]};
          dtm_pkg::OFS_PRESCALE_DIVIDER: rdata_d = {24'h00_0000, prescale_q[i]};
          dtm_pkg::OFS_CLOCK_UNIT_SETUP: rdata_d = {26'h000_0000, clock_setup_q[i]};
          dtm_pkg::OFS_MODE_SETUP: rdata_d = {23'h00_0000, mode_q[i]};
          dtm_pkg::OFS_IRQ_SETUP: rdata_d = {24'h00_0000, pend_q[i], irq_en_q[i]};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2; i++) begin
        prescale_q[i] <= dtm_pkg::PRESCALE_RST;
        clock_setup_q[i] <= dtm_pkg::CLOCK_SETUP_RST;
        mode_q[i] <= dtm_pkg::MODE_RST;
        irq_en_q[i] <= dtm_pkg::IRQ_RST;
        pend_q[i] <= dtm_pkg::IRQ_RST;
      end
      enable_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      pin_last_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        prescale_q[i] <= prescale_d[i];
        clock_setup_q[i] <= clock_setup_d[i];
        mode_q[i] <= mode_d[i];
        irq_en_q[i] <= irq_en_d[i];
        pend_q[i] <= pend_d[i];
      end
      enable_q <= {enable_d[1], enable_d[0]};
      rdata_q <= rdata_d;
      pin_meta_q <= input_b_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  assign rdata_out = rdata_q;
  assign timer_tick_out = tick;
  assign timer_global_enable_out = enable_q;

endmodule

// *** testbench/dtm_timer_regs_properties.sv ***
`timescale 1ns/10ps
module dtm_timer_regs_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [1:0] input_b_pin_in,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] timer_tick_out,
  input wire logic [1:0] timer_global_enable_out
);
  logic rd_q;
  logic [31:0] addr_q;
  logic mapped;
  logic [31:0] mode0;
  logic [31:0] mode1;
  // read data belong to the address of the previous cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= 1'b0;
      addr_q <= 32'h0;
    end else begin
      rd_q <= rd_in;
      addr_q <= addr_in;
    end
  end
  assign mapped = ((addr_q & dtm_pkg::PAGE_MASK) == dtm_pkg::FIRST_INSTANCE_BASE ||
      (addr_q & dtm_pkg::PAGE_MASK) == dtm_pkg::SECOND_INSTANCE_BASE) &&
      addr_q[7:0] <= 8'h20 && addr_q[1:0] == 2'h0;
  assign mode0 = dtm_pkg::FIRST_INSTANCE_BASE + 32'h18;
  assign mode1 = dtm_pkg::SECOND_INSTANCE_BASE + 32'h18;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_read_idle_zero: assert property (!rd_q |-> rdata_out == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_reads_zero: assert property (rd_q && !mapped |-> rdata_out == 32'h0)
    else $error("unmapped read returned data");
  a_count_upper_zero: assert property (rd_q && mapped && addr_q[7:0] <= 8'h0c
      |-> rdata_out[31:16] == 16'h0)
    else $error("upper half of a 16-bit register not zero");
  a_prescale_upper_zero: assert property (rd_q && mapped && addr_q[7:0] == 8'h10
      |-> rdata_out[31:8] == 24'h0)
    else $error("prescaler upper bits not zero");
  a_prescale_read_back: assert property (wr_in && addr_in == dtm_pkg::FIRST_INSTANCE_BASE + 32'h10
      ##1 !wr_in ##1 rd_in && addr_in == dtm_pkg::FIRST_INSTANCE_BASE + 32'h10
      |=> rdata_out[7:0] == $past(wdata_in[7:0], 3))
    else $error("prescaler read back differs from write");
  a_enable_set_one: assert property (wr_in && addr_in == mode0
      |=> timer_global_enable_out[0] == $past(wdata_in[6]))
    else $error("enable of first timer not taken from write");
  a_enable_set_two: assert property (wr_in && addr_in == mode1
      |=> timer_global_enable_out[1] == $past(wdata_in[6]))
    else $error("enable of second timer not taken from write");
  a_enable_held_one: assert property (!(wr_in && addr_in == mode0)
      |=> $stable(timer_global_enable_out[0]))
    else $error("enable of first timer moved without a write");
  a_tick_needs_enable: assert property ((timer_tick_out & ~(timer_global_enable_out |
      $past(timer_global_enable_out) | $past(timer_global_enable_out, 2))) == 2'h0)
    else $error("tick while timer disabled");
endmodule
bind dtm_timer_regs dtm_timer_regs_properties u_props (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .input_b_pin_in(input_b_pin_in), .rdata_out(rdata_out),
  .timer_tick_out(timer_tick_out), .timer_global_enable_out(timer_global_enable_out));

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] input_b_pin_in = 2'h0;
  logic [31:0] rdata_out;
  logic [1:0] timer_tick_out;
  logic [1:0] timer_global_enable_out;
  int miscompares = 0;
  int n_checks = 0;
  int g;
  logic [31:0] v;
  logic [31:0] b;
  logic [31:0] pl [3] = '{32'h0, 32'h1, 32'hff};

  always #12.5 clk_in = ~clk_in;

  dtm_timer_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .input_b_pin_in(input_b_pin_in),
    .rdata_out(rdata_out), .timer_tick_out(timer_tick_out),
    .timer_global_enable_out(timer_global_enable_out));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // read strobe one cycle, data sampled mid-cycle where they stand
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(nm, exp, rdata_out);
  endtask

  task automatic chk_gap(input string nm, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // bounded so a silent prescaler cannot hang the run
  task automatic wait_tick(input int i, output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (timer_tick_out[i] !== 1'b1 && n < 600);
  endtask

  function automatic logic [31:0] base(input int i);
    return (i == 0) ? dtm_pkg::FIRST_INSTANCE_BASE : dtm_pkg::SECOND_INSTANCE_BASE;
  endfunction

  initial begin
    #(25 * 40000);
    miscompares++;
    $display("[ERR] watchdog expected end seen hang");
    conclude();
  end

  initial begin
    void'($urandom(32'haa53));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      for (int o = 16; o <= 32; o += 4) rd_chk("reset value", base(i) + o, 32'h0);
      rd_chk("unmapped", base(i) + 32'h24, 32'h0);
      v = $urandom;
      b = $urandom;
      wr(base(i) + 32'h18, 32'h40);
      // enable settles in the edge's update phase, so look half a cycle later
      @(negedge clk_in);
      chk("enable", 32'h1, {31'h0, timer_global_enable_out[i]});
      wr(base(i) + 32'h04, v);
      wr(base(i) + 32'h08, b);
      wr(base(i) + 32'h18, 32'h0);
      wr(base(i) + 32'h04, ~v);
      wr(base(i) + 32'h08, ~b);
      rd_chk("reload a", base(i) + 32'h04, {16'h0, v[15:0]});
      rd_chk("reload b", base(i) + 32'h08, {16'h0, b[15:0]});
      wr(base(i) + 32'h00, b);
      wr(base(i) + 32'h0c, v);
      rd_chk("counter one", base(i), {16'h0, b[15:0]});
      rd_chk("counter two", base(i) + 32'h0c, {16'h0, v[15:0]});
      wr(base(i) + 32'h10, v);
      rd_chk("prescaler", base(i) + 32'h10, {24'h0, v[7:0]});
      wr(base(i) + 32'h14, 32'hffff_ffc0);
      rd_chk("clock setup", base(i) + 32'h14, 32'h0);
      $display("test registers %0d done", i);
    end
    rd_chk("other page", 32'h40f0_0000, 32'h0);
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        v = (k < 3) ? pl[k] : 32'($urandom_range(2, 40));
        wr(base(i) + 32'h10, v);
        wr(base(i) + 32'h18, 32'h40);
        wait_tick(i, g);
        wait_tick(i, g);
        chk_gap("tick gap", int'(v[7:0]) + 1, g);
        wr(base(i) + 32'h18, 32'h0);
      end
      $display("test tick %0d done", i);
    end
    // free running: new divider waits for the running count to expire
    wr(base(0) + 32'h10, 32'h3);
    wr(base(0) + 32'h18, 32'h40);
    wait_tick(0, g);
    wr(base(0) + 32'h10, 32'h7);
    wait_tick(0, g);
    chk_gap("old divider", 2, g);
    wait_tick(0, g);
    chk_gap("new divider", 8, g);
    // stop first: a train entered from stop keeps the divider it started with until a new start
    wr(base(0) + 32'h18, 32'h0);
    wr(base(0) + 32'h10, 32'h3);
    wr(base(0) + 32'h18, 32'hc0);
    wait_tick(0, g);
    wait_tick(0, g);
    wr(base(0) + 32'h10, 32'h7);
    wait_tick(0, g);
    wait_tick(0, g);
    chk_gap("train keeps divider", 4, g);
    wr(base(0) + 32'h18, 32'h2c0);
    wait_tick(0, g);
    wait_tick(0, g);
    chk_gap("train start divider", 8, g);
    wr(base(0) + 32'h18, 32'h0);
    $display("test divider update done");
    // counter one: reload on underflow, step on the tick, frozen when stopped
    v = 32'($urandom_range(1, 65535));
    wr(base(0) + 32'h10, 32'hff);
    wr(base(0) + 32'h18, 32'h40);
    wr(base(0) + 32'h04, v);
    wr(base(0) + 32'h00, 32'h0);
    wr(base(0) + 32'h14, 32'h1);
    wait_tick(0, g);
    rd_chk("counter one reload", base(0), v);
    wait_tick(0, g);
    rd_chk("counter one step", base(0), v - 32'h1);
    wr(base(0) + 32'h14, 32'h0);
    wait_tick(0, g);
    rd_chk("counter one stopped", base(0), v - 32'h1);
    rd_chk("pending a", base(0) + 32'h1c, 32'h10);
    wr(base(0) + 32'h20, 32'h1);
    rd_chk("pending a cleared", base(0) + 32'h1c, 32'h0);
    $display("test counter one done");
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      wr(base(i) + 32'h14, 32'h0);
      wr(base(i) + 32'h18, 32'h4b);
      wr(base(i) + 32'h0c, v);
      @(posedge clk_in);
      input_b_pin_in[i] <= 1'b1;
      repeat (6) @(posedge clk_in);
      input_b_pin_in[i] <= 1'b0;
      rd_chk("capture", base(i) + 32'h08, {16'h0, v[15:0]});
      rd_chk("pending b", base(i) + 32'h1c, 32'h20);
      wr(base(i) + 32'h20, 32'h2);
      rd_chk("pending cleared", base(i) + 32'h1c, 32'h0);
      wr(base(i) + 32'h18, 32'h0);
      $display("test capture %0d done", i);
    end
    conclude();
  end
endmodule
